// *** logic/psu_map.vh ***
// constants for the program flow and stack unit
`ifndef PSU_MAP_VH
`define PSU_MAP_VH

// operation codes on cmd_op_i
`define PSU_OP_JPDE 5'h00
`define PSU_OP_JPXA 5'h01
`define PSU_OP_JBCDE 5'h02
`define PSU_OP_JBCXA 5'h03
`define PSU_OP_CALL 5'h04
`define PSU_OP_LONG_SUBROUTINE_INVOKE 5'h05
`define PSU_OP_FIXED_AREA_INVOKE 5'h06
`define PSU_OP_RET 5'h07
`define PSU_OP_EXIT_AND_SKIP 5'h08
`define PSU_OP_INTERRUPT_EXIT 5'h09
`define PSU_OP_PUSH 5'h0A
`define PSU_OP_PUSHBS 5'h0B
`define PSU_OP_POP 5'h0C
`define PSU_OP_POPBS 5'h0D
`define PSU_OP_EI 5'h0E
`define PSU_OP_EISRC 5'h0F
`define PSU_OP_DI 5'h10
`define PSU_OP_DISRC 5'h11

// register addresses
`define PSU_A_PC 4'h0
`define PSU_A_SP 4'h1
`define PSU_A_XA 4'h2
`define PSU_A_HL 4'h3
`define PSU_A_DE 4'h4
`define PSU_A_BC 4'h5
`define PSU_A_PSW 4'h6
`define PSU_A_BANK 4'h7
`define PSU_A_SBS 4'h8
`define PSU_A_IPS 4'h9
`define PSU_A_IE 4'hA
`define PSU_A_STAT 4'hB

// register file pair indices; pair p takes nibble slots 2p and 2p+1
`define PSU_P_XA 2'h0
`define PSU_P_DE 2'h2

// field positions
`define PSU_SBS_MODE 3
`define PSU_IPS_IME 3
`define PSU_PSW_MBE 7
`define PSU_PSW_RBE 6
`define PSU_NB_MBE_L 3
`define PSU_NB_RBE_L 2
`define PSU_NB_MBE_X 1
`define PSU_NB_RBE_X 0

// frame sizes in nibbles
`define PSU_FR_LEG 3'h4
`define PSU_FR_EXT 3'h6
`define PSU_FR_PAIR 3'h2
`define PSU_FR_XRD 3'h5
`define PSU_FR_ONE 3'h1

// page wrap threshold, fixed area target mask and reset values
`define PSU_PAGE_WRAP 8'hFE
`define PSU_FIXED_AREA_INVOKE_MASK 13'h07FF
`define PSU_SBS_RST 4'h8
`define PSU_PSW_RST 8'h00
`define PSU_PC_RST 13'h0000

`endif

// *** logic/psu_frame.v ***
// stack frame layout: nibble data, write range and read size per operation
`timescale 1ns/10ps
`include "psu_map.vh"

module psu_frame (
    input wire [4:0] op_i,
    input wire ext_i,
    input wire [2:0] off_i,
    input wire [12:0] pc_i,
    input wire mbe_i,
    input wire rbe_i,
    input wire [3:0] hi_i,
    input wire [3:0] lo_i,
    output reg [3:0] wdata_o,
    output reg [2:0] wfirst_o,
    output reg [2:0] wlast_o,
    output reg [2:0] rcnt_o,
    output reg [2:0] radv_o
);

always @*
begin
    wdata_o = 4'h0;
    wfirst_o = `PSU_FR_ONE;
    wlast_o = `PSU_FR_PAIR;
    rcnt_o = `PSU_FR_PAIR;
    radv_o = `PSU_FR_PAIR;
    case (op_i)
        `PSU_OP_CALL, `PSU_OP_FIXED_AREA_INVOKE, `PSU_OP_LONG_SUBROUTINE_INVOKE:
        begin
            if (ext_i || op_i == `PSU_OP_LONG_SUBROUTINE_INVOKE)
            begin
                // extended frame, the top slot is left untouched
                wfirst_o = `PSU_FR_PAIR;
                wlast_o = `PSU_FR_EXT;
                case (off_i)
                    3'h2: wdata_o = {2'b00, mbe_i, rbe_i};
                    3'h3: wdata_o = pc_i[7:4];
                    3'h4: wdata_o = pc_i[3:0];
                    3'h5: wdata_o = {3'b000, pc_i[12]};
                    default: wdata_o = pc_i[11:8];
                endcase
            end
            else
            begin
                wlast_o = `PSU_FR_LEG;
                case (off_i)
                    3'h1: wdata_o = pc_i[7:4];
                    3'h2: wdata_o = pc_i[3:0];
                    3'h3: wdata_o = {mbe_i, rbe_i, 1'b0, pc_i[12]};
                    default: wdata_o = pc_i[11:8];
                endcase
            end
        end
        `PSU_OP_PUSH, `PSU_OP_PUSHBS:
            wdata_o = (off_i == `PSU_FR_ONE) ? hi_i : lo_i;
        `PSU_OP_RET, `PSU_OP_EXIT_AND_SKIP:
        begin
            rcnt_o = ext_i ? `PSU_FR_XRD : `PSU_FR_LEG;
            radv_o = ext_i ? `PSU_FR_EXT : `PSU_FR_LEG;
        end
        `PSU_OP_INTERRUPT_EXIT:
        begin
            rcnt_o = `PSU_FR_EXT;
            radv_o = `PSU_FR_EXT;
        end
        default:
            wdata_o = 4'h0;
    endcase
end

endmodule // psu_frame

// *** logic/psu_core.v ***
// program flow and stack unit: indirect jumps, calls, returns, push/pop, irq enables
`timescale 1ns/10ps
`include "psu_map.vh"

module psu_core #(
    parameter SPW = 9,
    parameter NSRC = 8
) (
    input wire clock_i,
    input wire nrst_i,
    input wire ce_i,
    input wire cmd_valid_i,
    input wire [4:0] cmd_op_i,
    input wire [12:0] cmd_arg_i,
    input wire [1:0] cmd_len_i,
    output reg cmd_ready_o,
    output reg skip_o,
    output reg [12:0] pc_o,
    output reg [SPW-1:0] sp_o,
    output reg [7:0] psw_o,
    output reg ime_o,
    output reg [NSRC-1:0] ie_o,
    output reg [SPW-1:0] mem_addr_o,
    output reg [3:0] mem_wdata_o,
    output reg mem_we_o,
    output reg mem_re_o,
    input wire [3:0] mem_rdata_i,
    input wire [3:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output reg [15:0] reg_rdata_o
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_IDLE = 2'h0;
localparam ST_WR = 2'h1;
localparam ST_RD = 2'h2;
localparam ST_FIN = 2'h3;

reg [1:0] state;
reg [4:0] op_q;
reg [12:0] arg_q;
reg [12:0] ret_pc;
reg [2:0] off;
reg rd_v;
reg [2:0] rd_idx;
reg [3:0] rf [0:7];
reg [3:0] rb [0:5];
reg [3:0] memory_bank_select;
reg [1:0] register_bank_select;
reg [3:0] stack_bank_select;
reg [3:0] interrupt_priority_select_reg;
reg [15:0] rd_mux;
integer i;

wire ext_mode = ~stack_bank_select[`PSU_SBS_MODE];
wire [1:0] pr = arg_q[1:0];
wire [1:0] cpr = cmd_arg_i[1:0];
wire is_bs = (op_q == `PSU_OP_PUSHBS);
wire [3:0] f_hi = is_bs ? memory_bank_select : rf[{pr, 1'b0}];
wire [3:0] f_lo = is_bs ? {2'b00, register_bank_select} : rf[{pr, 1'b1}];
wire [3:0] f_wdata;
wire [2:0] f_first;
wire [2:0] f_last;
wire [2:0] f_rcnt;
wire [2:0] f_radv;
wire [2:0] src = cmd_arg_i[2:0];
// the wrap is decided on the address of the jump's own first byte
wire [4:0] page = pc_o[12:8] + {4'h0, pc_o[7:0] >= `PSU_PAGE_WRAP};
wire [12:0] next_pc = pc_o + {11'h000, cmd_len_i};

psu_frame u_frame (
    .op_i(op_q),
    .ext_i(ext_mode),
    .off_i(off),
    .pc_i(ret_pc),
    .mbe_i(psw_o[`PSU_PSW_MBE]),
    .rbe_i(psw_o[`PSU_PSW_RBE]),
    .hi_i(f_hi),
    .lo_i(f_lo),
    .wdata_o(f_wdata),
    .wfirst_o(f_first),
    .wlast_o(f_last),
    .rcnt_o(f_rcnt),
    .radv_o(f_radv)
);

////////////////////////////////////////////////////////////////////////////////
// register read mux

always @*
begin
    rd_mux = 16'h0000;
    case (reg_addr_i)
        `PSU_A_PC: rd_mux = {3'h0, pc_o};
        `PSU_A_SP: rd_mux = {{(16-SPW){1'b0}}, sp_o};
        `PSU_A_XA, `PSU_A_HL, `PSU_A_DE, `PSU_A_BC:
            rd_mux = {8'h00, rf[{reg_addr_i[1:0] - 2'h2, 1'b0}],
                rf[{reg_addr_i[1:0] - 2'h2, 1'b1}]};
        `PSU_A_PSW: rd_mux = {8'h00, psw_o};
        `PSU_A_BANK: rd_mux = {10'h000, register_bank_select, memory_bank_select};
        `PSU_A_SBS: rd_mux = {12'h000, stack_bank_select};
        `PSU_A_IPS: rd_mux = {12'h000, interrupt_priority_select_reg[3:0]};
        `PSU_A_IE: rd_mux = {{(16-NSRC){1'b0}}, ie_o};
        `PSU_A_STAT: rd_mux = {14'h0000, ext_mode, ~cmd_ready_o};
        default: rd_mux = 16'h0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// main sequencer

always @(posedge clock_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        state <= ST_IDLE;
        op_q <= 5'h00;
        arg_q <= 13'h0000;
        ret_pc <= 13'h0000;
        off <= 3'h0;
        rd_v <= 1'b0;
        rd_idx <= 3'h0;
        for (i = 0; i < 8; i = i + 1)
            rf[i] <= 4'h0;
        for (i = 0; i < 6; i = i + 1)
            rb[i] <= 4'h0;
        memory_bank_select <= 4'h0;
        register_bank_select <= 2'h0;
        stack_bank_select <= `PSU_SBS_RST;
        interrupt_priority_select_reg <= 4'h0;
        cmd_ready_o <= 1'b1;
        skip_o <= 1'b0;
        pc_o <= `PSU_PC_RST;
        sp_o <= {SPW{1'b0}};
        psw_o <= `PSU_PSW_RST;
        ime_o <= 1'b0;
        ie_o <= {NSRC{1'b0}};
        mem_addr_o <= {SPW{1'b0}};
        mem_wdata_o <= 4'h0;
        mem_we_o <= 1'b0;
        mem_re_o <= 1'b0;
        reg_rdata_o <= 16'h0000;
    end
    else if (ce_i)
    begin
        mem_we_o <= 1'b0;
        mem_re_o <= 1'b0;
        skip_o <= 1'b0;
        if (reg_re_i)
            reg_rdata_o <= rd_mux;
        // software writes only land while no instruction is in flight
        if (reg_we_i && state == ST_IDLE && !cmd_valid_i)
        begin
            case (reg_addr_i)
                `PSU_A_PC: pc_o <= reg_wdata_i[12:0];
                `PSU_A_SP: sp_o <= reg_wdata_i[SPW-1:0];
                `PSU_A_XA, `PSU_A_HL, `PSU_A_DE, `PSU_A_BC:
                begin
                    rf[{reg_addr_i[1:0] - 2'h2, 1'b0}] <= reg_wdata_i[7:4];
                    rf[{reg_addr_i[1:0] - 2'h2, 1'b1}] <= reg_wdata_i[3:0];
                end
                `PSU_A_PSW: psw_o <= reg_wdata_i[7:0];
                `PSU_A_BANK:
                begin
                    memory_bank_select <= reg_wdata_i[3:0];
                    register_bank_select <= reg_wdata_i[5:4];
                end
                `PSU_A_SBS: stack_bank_select <= reg_wdata_i[3:0];
                `PSU_A_IPS:
                begin
                    interrupt_priority_select_reg <= reg_wdata_i[3:0];
                    ime_o <= reg_wdata_i[`PSU_IPS_IME];
                end
                `PSU_A_IE: ie_o <= reg_wdata_i[NSRC-1:0];
                default: ;
            endcase
        end
        if (rd_v)
            rb[rd_idx] <= mem_rdata_i;
        rd_v <= 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    op_q <= cmd_op_i;
                    arg_q <= cmd_arg_i;
                    ret_pc <= next_pc;
                    off <= 3'h0;
                    case (cmd_op_i)
                        `PSU_OP_JPDE:
                            pc_o <= {page, rf[{`PSU_P_DE, 1'b0}],
                                rf[{`PSU_P_DE, 1'b1}]};
                        `PSU_OP_JPXA:
                            pc_o <= {page, rf[{`PSU_P_XA, 1'b0}],
                                rf[{`PSU_P_XA, 1'b1}]};
                        `PSU_OP_JBCDE:
                            pc_o <= {rf[6][0], rf[7], rf[4], rf[5]};
                        `PSU_OP_JBCXA:
                            pc_o <= {rf[6][0], rf[7], rf[0], rf[1]};
                        `PSU_OP_EI:
                        begin
                            ime_o <= 1'b1;
                            interrupt_priority_select_reg[`PSU_IPS_IME] <= 1'b1;
                        end
                        `PSU_OP_DI:
                        begin
                            ime_o <= 1'b0;
                            interrupt_priority_select_reg[`PSU_IPS_IME] <= 1'b0;
                        end
                        `PSU_OP_EISRC: ie_o[src] <= 1'b1;
                        `PSU_OP_DISRC: ie_o[src] <= 1'b0;
                        `PSU_OP_CALL, `PSU_OP_LONG_SUBROUTINE_INVOKE, `PSU_OP_FIXED_AREA_INVOKE,
                        `PSU_OP_PUSH, `PSU_OP_PUSHBS:
                        begin
                            state <= ST_WR;
                            cmd_ready_o <= 1'b0;
                        end
                        `PSU_OP_RET, `PSU_OP_EXIT_AND_SKIP, `PSU_OP_INTERRUPT_EXIT,
                        `PSU_OP_POP, `PSU_OP_POPBS:
                        begin
                            state <= ST_RD;
                            cmd_ready_o <= 1'b0;
                        end
                        default: ;
                    endcase
                end
            end
            ST_WR:
            begin
                // one nibble per cycle, from the top of the frame downward
                if (off < f_first)
                    off <= f_first;
                else
                begin
                    mem_we_o <= 1'b1;
                    mem_addr_o <= sp_o - {{(SPW-3){1'b0}}, off};
                    mem_wdata_o <= f_wdata;
                    off <= off + 3'h1;
                    if (off == f_last)
                        state <= ST_FIN;
                end
            end
            ST_RD:
            begin
                mem_re_o <= 1'b1;
                mem_addr_o <= sp_o + {{(SPW-3){1'b0}}, off};
                rd_v <= 1'b1;
                rd_idx <= off;
                off <= off + 3'h1;
                if (off == f_rcnt - 3'h1)
                    state <= ST_FIN;
            end
            default:
            begin
                // read data of the last nibble lands this cycle; apply one later
                if (!rd_v)
                begin
                    state <= ST_IDLE;
                    cmd_ready_o <= 1'b1;
                    case (op_q)
                        `PSU_OP_CALL, `PSU_OP_LONG_SUBROUTINE_INVOKE:
                        begin
                            sp_o <= sp_o - {{(SPW-3){1'b0}}, f_last};
                            pc_o <= arg_q;
                        end
                        `PSU_OP_FIXED_AREA_INVOKE:
                        begin
                            sp_o <= sp_o - {{(SPW-3){1'b0}}, f_last};
                            pc_o <= arg_q & `PSU_FIXED_AREA_INVOKE_MASK;
                        end
                        `PSU_OP_PUSH, `PSU_OP_PUSHBS:
                            sp_o <= sp_o - {{(SPW-3){1'b0}}, f_last};
                        `PSU_OP_RET, `PSU_OP_EXIT_AND_SKIP, `PSU_OP_INTERRUPT_EXIT:
                        begin
                            sp_o <= sp_o + {{(SPW-3){1'b0}}, f_radv};
                            pc_o <= {rb[1][0], rb[0], rb[3], rb[2]};
                            // interrupt exit restores all of psw; otherwise only bank flags move, and a legacy exit-and-skip restores MBE alone
                            if (op_q == `PSU_OP_INTERRUPT_EXIT)
                                psw_o <= {rb[5], rb[4]};
                            else if (ext_mode)
                            begin
                                psw_o[`PSU_PSW_MBE] <= rb[4][`PSU_NB_MBE_X];
                                psw_o[`PSU_PSW_RBE] <= rb[4][`PSU_NB_RBE_X];
                            end
                            else
                            begin
                                psw_o[`PSU_PSW_MBE] <= rb[1][`PSU_NB_MBE_L];
                                if (op_q == `PSU_OP_RET)
                                    psw_o[`PSU_PSW_RBE] <= rb[1][`PSU_NB_RBE_L];
                            end
                            if (op_q == `PSU_OP_EXIT_AND_SKIP)
                                skip_o <= 1'b1;
                        end
                        `PSU_OP_POP:
                        begin
                            rf[{pr, 1'b1}] <= rb[0];
                            rf[{pr, 1'b0}] <= rb[1];
                            sp_o <= sp_o + {{(SPW-3){1'b0}}, f_radv};
                        end
                        default:
                        begin
                            register_bank_select <= rb[0][1:0];
                            memory_bank_select <= rb[1];
                            sp_o <= sp_o + {{(SPW-3){1'b0}}, f_radv};
                        end
                    endcase
                end
            end
        endcase
    end
end

endmodule // psu_core

// *** sim/psu_core_props.sv ***
// checker: port-level relations of the program flow and stack unit
`timescale 1ns/10ps
`include "psu_map.vh"

module psu_core_props #(
    parameter SPW = 9,
    parameter NSRC = 8
) (
    input wire clock_i,
    input wire nrst_i,
    input wire ce_i,
    input wire cmd_valid_i,
    input wire [4:0] cmd_op_i,
    input wire [12:0] cmd_arg_i,
    input wire cmd_ready_o,
    input wire [12:0] pc_o,
    input wire [SPW-1:0] sp_o,
    input wire ime_o,
    input wire [NSRC-1:0] ie_o,
    input wire [SPW-1:0] mem_addr_o,
    input wire mem_we_o
);
wire take = cmd_valid_i && cmd_ready_o && ce_i;
logic [SPW-1:0] sp_q;
logic [12:0] arg_q;

// operands captured at the taking edge; the command bus may move on afterwards
always @(posedge clock_i)
begin
    if (take)
    begin
        sp_q <= sp_o;
        arg_q <= cmd_arg_i;
    end
end

default clocking cb @(posedge clock_i);
endclocking
default disable iff (!nrst_i);

////////////////////////////////////////////////////////////////////////////////
property p_page_keep;
    take && cmd_op_i == `PSU_OP_JPDE && pc_o[7:0] < `PSU_PAGE_WRAP
    |=> pc_o[12:8] == $past(pc_o[12:8]);
endproperty
a_page_keep: assert property (p_page_keep) else $error("page jump moved upper pc");

property p_page_wrap;
    take && (cmd_op_i == `PSU_OP_JPDE || cmd_op_i == `PSU_OP_JPXA) && pc_o[7:0] >= `PSU_PAGE_WRAP
    |=> pc_o[12:8] == $past(pc_o[12:8]) + 5'h01;
endproperty
a_page_wrap: assert property (p_page_wrap) else $error("page jump missed next page");

property p_fixed_call;
    take && cmd_op_i == `PSU_OP_FIXED_AREA_INVOKE |=> ##[1:16] (cmd_ready_o && pc_o == {2'h0, arg_q[10:0]});
endproperty
a_fixed_call: assert property (p_fixed_call) else $error("fixed call target wrong");

property p_push_order;
    take && cmd_op_i == `PSU_OP_PUSH
    |-> ##[1:3] (mem_we_o && mem_addr_o == sp_q - 1'h1) ##1 (mem_we_o && mem_addr_o == sp_q - 2'h2);
endproperty
a_push_order: assert property (p_push_order) else $error("push write order wrong");

property p_pop_sp;
    take && cmd_op_i == `PSU_OP_POP |=> ##[1:16] (cmd_ready_o && sp_o == sp_q + 2'h2);
endproperty
a_pop_sp: assert property (p_pop_sp) else $error("pop stack pointer wrong");

property p_ei;
    take && cmd_op_i == `PSU_OP_EI |=> ime_o;
endproperty
a_ei: assert property (p_ei) else $error("master enable not set");

property p_di;
    take && cmd_op_i == `PSU_OP_DI |=> !ime_o;
endproperty
a_di: assert property (p_di) else $error("master enable not cleared");

property p_src_on;
    take && cmd_op_i == `PSU_OP_EISRC |=> ie_o[$past(cmd_arg_i[2:0])];
endproperty
a_src_on: assert property (p_src_on) else $error("source enable not set");

c_call: cover property (take && cmd_op_i == `PSU_OP_CALL);
c_interrupt_exit: cover property (take && cmd_op_i == `PSU_OP_INTERRUPT_EXIT);
c_src: cover property (take && cmd_op_i == `PSU_OP_EISRC);
endmodule // psu_core_props

bind psu_core psu_core_props #(.SPW(SPW), .NSRC(NSRC)) u_props (.clock_i, .nrst_i, .ce_i,
    .cmd_valid_i, .cmd_op_i, .cmd_arg_i, .cmd_ready_o, .pc_o, .sp_o, .ime_o, .ie_o,
    .mem_addr_o, .mem_we_o);

// *** sim/psu_core_tb.sv ***
// self-checking bench for the program flow and stack unit
`timescale 1ns/10ps
`include "psu_map.vh"

module psu_core_tb;
logic clock_i = 1'h0;
logic nrst_i = 1'h0;
logic ce_i = 1'h1;
logic cmd_valid_i = 1'h0;
logic reg_we_i = 1'h0;
logic reg_re_i = 1'h0;
logic [4:0] cmd_op_i = 5'h00;
logic [12:0] cmd_arg_i = 13'h0000;
logic [1:0] cmd_len_i = 2'h0;
logic [3:0] mem_rdata_i = 4'h0;
logic [3:0] reg_addr_i = 4'h0;
logic [15:0] reg_wdata_i = 16'h0000;
logic [15:0] reg_rdata_o;
logic cmd_ready_o, skip_o, ime_o, mem_we_o, mem_re_o;
logic [12:0] pc_o;
logic [8:0] sp_o, mem_addr_o;
logic [7:0] psw_o, ie_o;
logic [3:0] mem_wdata_o;
logic [3:0] mem [0:511];
logic skip_seen = 1'h0;
int fail_count = 0;
int samples_checked = 0;

psu_core #(.SPW(9), .NSRC(8)) dut (.clock_i, .nrst_i, .ce_i, .cmd_valid_i, .cmd_op_i,
    .cmd_arg_i, .cmd_len_i, .cmd_ready_o, .skip_o, .pc_o, .sp_o, .psw_o, .ime_o, .ie_o,
    .mem_addr_o, .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o);

initial forever #2.5 clock_i = ~clock_i;

// data memory; the unit latches read data at the edge that ends the read cycle
always @(posedge clock_i)
begin
    if (mem_we_o)
        mem[mem_addr_o] <= mem_wdata_o;
    if (skip_o)
        skip_seen <= 1'h1;
end

// idle read data is inverted so a stale capture never passes
always @*
    mem_rdata_i = mem_re_o ? mem[mem_addr_o] : ~mem[mem_addr_o];

////////////////////////////////////////////////////////////////////////////////
task close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask

task chk(input string nm, input [15:0] s, input [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", nm, e, s);
    end
endtask

task reg_wr(input [3:0] a, input [15:0] d);
    @(posedge clock_i);
    reg_we_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_we_i <= 1'h0;
endtask

task rchk(input string nm, input [3:0] a, input [15:0] e);
    @(posedge clock_i);
    reg_re_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_re_i <= 1'h0;
    #1 chk(nm, reg_rdata_o, e);
endtask

// issue one instruction and wait, bounded, for the unit to go idle
task cmd(input [4:0] op, input [12:0] arg, input [1:0] len);
    int n;
    @(posedge clock_i);
    cmd_valid_i <= 1'h1;
    cmd_op_i <= op;
    cmd_arg_i <= arg;
    cmd_len_i <= len;
    @(posedge clock_i);
    cmd_valid_i <= 1'h0;
    n = 0;
    // look after the edge has settled, not in the edge's own time step
    #1;
    while (cmd_ready_o !== 1'h1 && n < 40)
    begin
        @(posedge clock_i);
        #1;
        n++;
    end
    if (n == 40)
    begin
        fail_count++;
        close_out();
    end
endtask

// nibbles expected from address top downwards, first nibble in the top digits
task frm(input [8:0] top, input [23:0] e, input int n);
    for (int i = 0; i < n; i++)
        chk("stack", mem[top - i], e[4 * (n - 1 - i) +: 4]);
endtask

////////////////////////////////////////////////////////////////////////////////
task t_rst;
    rchk("mode", `PSU_A_SBS, 16'h0008);
    rchk("stat", `PSU_A_STAT, 16'h0000);
    $display("reset test done");
endtask

task t_jump;
    reg_wr(`PSU_A_DE, 16'h005A);
    reg_wr(`PSU_A_XA, 16'h00C3);
    reg_wr(`PSU_A_BC, 16'h0037);
    reg_wr(`PSU_A_PC, 16'h0123);
    cmd(`PSU_OP_JPDE, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h015A);
    reg_wr(`PSU_A_PC, 16'h02FE);
    cmd(`PSU_OP_JPDE, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h035A);
    reg_wr(`PSU_A_PC, 16'h02FF);
    cmd(`PSU_OP_JPXA, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h03C3);
    cmd(`PSU_OP_JBCDE, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h175A);
    cmd(`PSU_OP_JBCXA, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h17C3);
    $display("jump test done");
endtask

task t_legacy;
    reg_wr(`PSU_A_SP, 16'h0100);
    reg_wr(`PSU_A_PSW, 16'h00C0);
    reg_wr(`PSU_A_PC, 16'h1ABC);
    cmd(`PSU_OP_CALL, 13'h0456, 2'h3);
    frm(9'h0FF, 24'h00BFDA, 4);
    chk("sp", sp_o, 16'h00FC);
    chk("pc", pc_o, 16'h0456);
    reg_wr(`PSU_A_PSW, 16'h003F);
    cmd(`PSU_OP_RET, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h1ABF);
    chk("sp", sp_o, 16'h0100);
    chk("psw", psw_o, 16'h00FF);
    cmd(`PSU_OP_FIXED_AREA_INVOKE, 13'h1FFF, 2'h2);
    chk("pc", pc_o, 16'h07FF);
    chk("sp", sp_o, 16'h00FC);
    reg_wr(`PSU_A_SP, 16'h0100);
    reg_wr(`PSU_A_PC, 16'h1F00);
    cmd(`PSU_OP_LONG_SUBROUTINE_INVOKE, 13'h1234, 2'h3);
    frm(9'h0FD, 24'h00031F, 4);
    chk("sp", sp_o, 16'h00FA);
    chk("pc", pc_o, 16'h1234);
    mem[9'h0FE] = 4'h5;
    mem[9'h0FF] = 4'hA;
    cmd(`PSU_OP_INTERRUPT_EXIT, 13'h0000, 2'h1);
    chk("pc", pc_o, 16'h1F03);
    chk("psw", psw_o, 16'h00A5);
    chk("sp", sp_o, 16'h0100);
    $display("legacy frame test done");
endtask

task t_ext;
    reg_wr(`PSU_A_SBS, 16'h0000);
    rchk("stat", `PSU_A_STAT, 16'h0002);
    reg_wr(`PSU_A_SP, 16'h0100);
    reg_wr(`PSU_A_PSW, 16'h0040);
    reg_wr(`PSU_A_PC, 16'h0FED);
    cmd(`PSU_OP_CALL, 13'h0800, 2'h2);
    frm(9'h0FE, 24'h01EF0F, 5);
    chk("sp", sp_o, 16'h00FA);
    reg_wr(`PSU_A_PSW, 16'h0080);
    skip_seen = 1'h0;
    cmd(`PSU_OP_EXIT_AND_SKIP, 13'h0000, 2'h1);
    repeat (2) @(posedge clock_i);
    chk("pc", pc_o, 16'h0FEF);
    chk("sp", sp_o, 16'h0100);
    chk("psw", psw_o, 16'h0040);
    chk("skip", skip_seen, 16'h0001);
    reg_wr(`PSU_A_SBS, 16'h0008);
    $display("extended frame test done");
endtask

task t_stack;
    reg_wr(`PSU_A_SP, 16'h0100);
    reg_wr(`PSU_A_BANK, 16'h002F);
    cmd(`PSU_OP_PUSH, {11'h000, `PSU_P_DE}, 2'h1);
    cmd(`PSU_OP_PUSHBS, 13'h0000, 2'h1);
    frm(9'h0FF, 24'h005AF2, 4);
    chk("sp", sp_o, 16'h00FC);
    reg_wr(`PSU_A_BANK, 16'h0000);
    cmd(`PSU_OP_POPBS, 13'h0000, 2'h1);
    rchk("bank", `PSU_A_BANK, 16'h002F);
    cmd(`PSU_OP_POP, {11'h000, `PSU_P_XA}, 2'h1);
    rchk("xa", `PSU_A_XA, 16'h005A);
    chk("sp", sp_o, 16'h0100);
    $display("push pop test done");
endtask

task t_irq;
    cmd(`PSU_OP_EI, 13'h0000, 2'h1);
    chk("ime", ime_o, 16'h0001);
    rchk("ips", `PSU_A_IPS, 16'h0008);
    for (int s = 0; s < 8; s++)
        cmd(`PSU_OP_EISRC, s[12:0], 2'h1);
    chk("ie", ie_o, 16'h00FF);
    cmd(`PSU_OP_DISRC, 13'h0003, 2'h1);
    chk("ie", ie_o, 16'h00F7);
    cmd(`PSU_OP_DI, 13'h0000, 2'h1);
    chk("ime", ime_o, 16'h0000);
    chk("ie", ie_o, 16'h00F7);
    $display("interrupt enable test done");
endtask

initial
begin
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'h1;
    t_rst();
    t_jump();
    t_legacy();
    t_ext();
    t_stack();
    t_irq();
    close_out();
end
endmodule // psu_core_tb
